// ### hpc_defs.svh
// Register offsets, control bit positions and reset values for the host port
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

`define HPC_OFS_ADDR_PIN_DIRECTION 32'h43000020
`define HPC_OFS_ADDR_PIN_DATA      32'h43000024
`define HPC_OFS_HOST_PORT_CONTROL  32'h43000030
`define HPC_OFS_HOST_WRITE_ADDRESS 32'h43000034
`define HPC_OFS_HOST_READ_ADDRESS  32'h43000038

`define HPC_BIT_ADDR_REG_SELECT    11
`define HPC_BIT_LOOPBACK_SELECT    10
`define HPC_BIT_SPLIT_ADDR_MODE    9
`define HPC_BIT_HALFWORD_COPY      8
`define HPC_BIT_PORT_HOLD_RESET    7
`define HPC_BIT_HOST_RESET_REQ     6
`define HPC_BIT_EXTENDED_ADDR_MODE 5
`define HPC_BIT_PREFETCH           4
`define HPC_BIT_READY_STATUS       3
`define HPC_BIT_TO_HOST_IRQ        2
`define HPC_BIT_TO_CPU_IRQ         1
`define HPC_BIT_HALFWORD_ORDER     0

`define HPC_RST_ADDR_PIN_DIRECTION 32'h00000000
`define HPC_RST_ADDR_PIN_DATA      32'h00000000
`define HPC_RST_ADDRESS            32'h00000000
`define HPC_RST_PORT_HOLD_RESET    1'b1

`define HPC_ADDR_PIN_COUNT         16
`define HPC_ADDR_PIN_GROUPS        2

`endif

// ### hpc_pkg.sv
// Types shared by the host port control files
package hpc_pkg;
  typedef enum logic [1:0] {
    hpc_sel_ctrl     = 2'b00,
    hpc_sel_data_inc = 2'b01,
    hpc_sel_addr     = 2'b10,
    hpc_sel_data     = 2'b11
  } hpc_access_sel_t;
endpackage

// ### hpc_addr_gpio.sv
// General purpose I/O bank for the host address pins
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_addr_gpio #(
  parameter int REG_W  = 32,
  parameter int PINS   = `HPC_ADDR_PIN_COUNT,
  parameter int GROUPS = `HPC_ADDR_PIN_GROUPS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              dir_wr,
  input  wire logic              data_wr,
  input  wire logic [REG_W-1:0]  wdata,
  input  wire logic [GROUPS-1:0] pin_function_enable,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [REG_W-1:0]  addr_dir_bits,
  output logic      [REG_W-1:0]  addr_data_read,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe_n
);
  localparam int PER_GROUP = PINS / GROUPS;

  logic [REG_W-1:0] addr_data_bits;

  // Direction register, all bits stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_dir_bits <= `HPC_RST_ADDR_PIN_DIRECTION;
    end else if (dir_wr) begin
      addr_dir_bits <= wdata;
    end
  end

  // Upper bits have no pins; kept as plain storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_data_bits[REG_W-1:PINS] <= '0;
    end else if (data_wr) begin
      addr_data_bits[REG_W-1:PINS] <= wdata[REG_W-1:PINS];
    end
  end

  assign addr_data_read[REG_W-1:PINS] = addr_data_bits[REG_W-1:PINS];

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic gp_mode;
    logic gp_input;
    assign gp_mode  = pin_function_enable[i / PER_GROUP];
    assign gp_input = gp_mode && !addr_dir_bits[i];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        addr_data_bits[i] <= 1'b0;
      end else if (data_wr && !gp_input) begin
        addr_data_bits[i] <= wdata[i];
      end
    end

    assign addr_data_read[i] = gp_input ? pin_in[i] : addr_data_bits[i];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i]  <= addr_data_bits[i];
        pin_oe_n[i] <= !(gp_mode && addr_dir_bits[i]);
      end
    end
  end

  // Output drive follows direction
  pin_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin_function_enable[0] && addr_dir_bits[0] |=> !pin_oe_n[0])
    else $error("enabled output pin not driven");
endmodule

// ### hpc_host_port_ctrl.sv
// Host port control, address registers and address pin I/O
// Functional notes
// - GPIO address pin: direction 0 input, 1 output; ignored in port function
// - Input pin: data read returns pin level, data write ignored
// - Output pin: written data driven on pin and read back
// - Bit 11 picks read or write address register in split mode
// - Bit 9 host writable: 1 split address registers, 0 single view
// - Bit 8 is read-only copy of halfword order bit 0
// - Bit 7 resets to 1, holds port reset, processor-only access
// - Host writing 1 to bit 4 starts prefetch; reads return 0
// - Bit 3 host readable, shows internal ready, opposite to ready pin
// - Writing 1 to bit 2 raises host interrupt; pin is inverted
// - Writing 1 to bit 1 from either side interrupts the processor
// - Bit 10 loopback selector reads 0 for both sides
// - Write address register: reset 0, host RW, processor RO, select 10
// - Read address register: reset 0, host RW, processor RO, select 10
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_host_port_ctrl #(
  parameter int DATA_W = 32,
  parameter int PINS   = `HPC_ADDR_PIN_COUNT,
  parameter int GROUPS = `HPC_ADDR_PIN_GROUPS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cpu_rd,
  input  wire logic              cpu_wr,
  input  wire logic [31:0]       cpu_addr,
  input  wire logic [DATA_W-1:0] cpu_wdata,
  output logic      [DATA_W-1:0] cpu_rdata,
  input  wire logic              host_rd,
  input  wire logic              host_wr,
  input  wire logic [1:0]        access_select_pins,
  input  wire logic [DATA_W-1:0] host_wdata,
  output logic      [DATA_W-1:0] host_rdata,
  input  wire logic              port_ready,
  input  wire logic [GROUPS-1:0] pin_function_enable,
  input  wire logic [PINS-1:0]   host_addr_pins_in,
  output logic      [PINS-1:0]   host_addr_pins_out,
  output logic      [PINS-1:0]   host_addr_pins_oe_n,
  output logic                   ready_pin_n,
  output logic                   host_irq_pin_n,
  output logic                   cpu_irq,
  output logic                   port_hold_reset,
  output logic                   prefetch_start,
  output logic                   split_addr_mode,
  output logic                   halfword_order,
  output logic      [DATA_W-1:0] host_write_address,
  output logic      [DATA_W-1:0] host_read_address
);
  logic              addr_reg_select;
  logic              host_reset_req;
  logic              extended_addr_mode;
  logic              to_host_irq;
  logic              to_cpu_irq;
  logic [DATA_W-1:0] control_view;
  logic [DATA_W-1:0] addr_dir_bits;
  logic [DATA_W-1:0] addr_data_read;
  logic              cpu_sel_dir;
  logic              cpu_sel_dat;
  logic              cpu_sel_ctl;
  logic              cpu_sel_waddr;
  logic              cpu_sel_raddr;
  logic              host_ctl_wr;
  logic              host_addr_wr;
  logic              cpu_ctl_wr;
  logic [DATA_W-1:0] next_cpu_rdata;
  logic [DATA_W-1:0] next_host_rdata;
  hpc_pkg::hpc_access_sel_t host_sel;

  assign host_sel = hpc_pkg::hpc_access_sel_t'(access_select_pins);

  // Processor address decode
  assign cpu_sel_dir   = (cpu_addr == `HPC_OFS_ADDR_PIN_DIRECTION);
  assign cpu_sel_dat   = (cpu_addr == `HPC_OFS_ADDR_PIN_DATA);
  assign cpu_sel_ctl   = (cpu_addr == `HPC_OFS_HOST_PORT_CONTROL);
  assign cpu_sel_waddr = (cpu_addr == `HPC_OFS_HOST_WRITE_ADDRESS);
  assign cpu_sel_raddr = (cpu_addr == `HPC_OFS_HOST_READ_ADDRESS);
  assign cpu_ctl_wr    = cpu_wr && cpu_sel_ctl;

  assign host_ctl_wr  = host_wr && (host_sel == hpc_pkg::hpc_sel_ctrl) && !port_hold_reset;
  assign host_addr_wr = host_wr && (host_sel == hpc_pkg::hpc_sel_addr) && !port_hold_reset;

  // Address pin GPIO bank
  hpc_addr_gpio #(
    .REG_W  (DATA_W),
    .PINS   (PINS),
    .GROUPS (GROUPS)
  ) u_addr_gpio (
    .clk                 (clk),
    .rst_n               (rst_n),
    .dir_wr              (cpu_wr && cpu_sel_dir),
    .data_wr             (cpu_wr && cpu_sel_dat),
    .wdata               (cpu_wdata),
    .pin_function_enable (pin_function_enable),
    .pin_in              (host_addr_pins_in),
    .addr_dir_bits       (addr_dir_bits),
    .addr_data_read      (addr_data_read),
    .pin_out             (host_addr_pins_out),
    .pin_oe_n            (host_addr_pins_oe_n)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_hold_reset <= `HPC_RST_PORT_HOLD_RESET;
    end else if (cpu_ctl_wr) begin
      port_hold_reset <= cpu_wdata[`HPC_BIT_PORT_HOLD_RESET];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg_select    <= 1'b0;
      split_addr_mode    <= 1'b0;
      host_reset_req     <= 1'b0;
      extended_addr_mode <= 1'b0;
      halfword_order     <= 1'b0;
    end else if (host_ctl_wr) begin
      addr_reg_select    <= host_wdata[`HPC_BIT_ADDR_REG_SELECT];
      split_addr_mode    <= host_wdata[`HPC_BIT_SPLIT_ADDR_MODE];
      host_reset_req     <= host_wdata[`HPC_BIT_HOST_RESET_REQ];
      extended_addr_mode <= host_wdata[`HPC_BIT_EXTENDED_ADDR_MODE];
      halfword_order     <= host_wdata[`HPC_BIT_HALFWORD_ORDER];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_host_irq <= 1'b0;
    end else if ((host_ctl_wr && host_wdata[`HPC_BIT_TO_HOST_IRQ]) ||
                 (cpu_ctl_wr && cpu_wdata[`HPC_BIT_TO_HOST_IRQ])) begin
      to_host_irq <= 1'b1;
    end else if (host_ctl_wr || cpu_ctl_wr) begin
      to_host_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cpu_irq <= 1'b0;
    end else if ((host_ctl_wr && host_wdata[`HPC_BIT_TO_CPU_IRQ]) ||
                 (cpu_ctl_wr && cpu_wdata[`HPC_BIT_TO_CPU_IRQ])) begin
      to_cpu_irq <= 1'b1;
    end else if (host_ctl_wr || cpu_ctl_wr) begin
      to_cpu_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_irq_pin_n <= 1'b1;
      cpu_irq        <= 1'b0;
      ready_pin_n    <= 1'b1;
    end else begin
      host_irq_pin_n <= !to_host_irq;
      cpu_irq        <= to_cpu_irq;
      ready_pin_n    <= !port_ready;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prefetch_start <= 1'b0;
    end else begin
      prefetch_start <= host_ctl_wr && host_wdata[`HPC_BIT_PREFETCH];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_write_address <= `HPC_RST_ADDRESS;
    end else if (host_addr_wr && (!split_addr_mode || !addr_reg_select)) begin
      host_write_address <= host_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_read_address <= `HPC_RST_ADDRESS;
    end else if (host_addr_wr && (!split_addr_mode || addr_reg_select)) begin
      host_read_address <= host_wdata;
    end
  end

  always_comb begin
    control_view                              = '0;
    control_view[`HPC_BIT_ADDR_REG_SELECT]    = addr_reg_select;
    control_view[`HPC_BIT_LOOPBACK_SELECT]    = 1'b0;
    control_view[`HPC_BIT_SPLIT_ADDR_MODE]    = split_addr_mode;
    control_view[`HPC_BIT_HALFWORD_COPY]      = halfword_order;
    control_view[`HPC_BIT_HOST_RESET_REQ]     = host_reset_req;
    control_view[`HPC_BIT_EXTENDED_ADDR_MODE] = extended_addr_mode;
    control_view[`HPC_BIT_PREFETCH]           = 1'b0;
    control_view[`HPC_BIT_TO_HOST_IRQ]        = to_host_irq;
    control_view[`HPC_BIT_TO_CPU_IRQ]         = to_cpu_irq;
    control_view[`HPC_BIT_HALFWORD_ORDER]     = halfword_order;
  end

  // Processor read mux, unmapped reads zero
  always_comb begin
    next_cpu_rdata = '0;
    if (cpu_sel_dir) begin
      next_cpu_rdata = addr_dir_bits;
    end else if (cpu_sel_dat) begin
      next_cpu_rdata = addr_data_read;
    end else if (cpu_sel_ctl) begin
      next_cpu_rdata = control_view;
      next_cpu_rdata[`HPC_BIT_PORT_HOLD_RESET] = port_hold_reset;
    end else if (cpu_sel_waddr) begin
      next_cpu_rdata = host_write_address;
    end else if (cpu_sel_raddr) begin
      next_cpu_rdata = host_read_address;
    end
  end

  // Host read mux
  always_comb begin
    next_host_rdata = '0;
    unique case (host_sel)
      hpc_pkg::hpc_sel_ctrl: begin
        next_host_rdata = control_view;
        next_host_rdata[`HPC_BIT_READY_STATUS] = port_ready;
      end
      hpc_pkg::hpc_sel_addr: begin
        next_host_rdata = (split_addr_mode && addr_reg_select) ?
                          host_read_address : host_write_address;
      end
      hpc_pkg::hpc_sel_data_inc: begin
        next_host_rdata = '0;
      end
      hpc_pkg::hpc_sel_data: begin
        next_host_rdata = '0;
      end
    endcase
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= '0;
    end else if (cpu_rd) begin
      cpu_rdata <= next_cpu_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= '0;
    end else if (host_rd) begin
      host_rdata <= next_host_rdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  hold_reset_a: assert property (
    !cpu_ctl_wr |=> port_hold_reset == $past(port_hold_reset))
    else $error("hold reset changed without processor write");

  pin_input_a: assert property (
    cpu_rd && cpu_sel_dat && pin_function_enable[0] && !addr_dir_bits[0]
    |=> cpu_rdata[0] == $past(host_addr_pins_in[0]))
    else $error("input pin level not returned");

  split_select_a: assert property (
    host_addr_wr && split_addr_mode && addr_reg_select
    |=> host_read_address == $past(host_wdata) && $stable(host_write_address))
    else $error("split mode read address routing wrong");

  single_view_a: assert property (
    host_addr_wr && !split_addr_mode
    |=> host_read_address == host_write_address)
    else $error("single mode addresses differ");

  split_write_a: assert property (
    host_addr_wr && split_addr_mode && !addr_reg_select
    |=> $stable(host_read_address))
    else $error("read address touched by write select");

  halfword_copy_a: assert property (
    host_rd && host_sel == hpc_pkg::hpc_sel_ctrl
    |=> host_rdata[`HPC_BIT_HALFWORD_COPY] == $past(halfword_order))
    else $error("halfword copy mismatch");

  prefetch_zero_a: assert property (
    host_rd && host_sel == hpc_pkg::hpc_sel_ctrl
    |=> !host_rdata[`HPC_BIT_PREFETCH] && !host_rdata[`HPC_BIT_LOOPBACK_SELECT])
    else $error("prefetch or loopback bit read nonzero");

  loopback_zero_a: assert property (
    cpu_rd && cpu_sel_ctl |=> !cpu_rdata[`HPC_BIT_LOOPBACK_SELECT])
    else $error("loopback bit read nonzero by processor");

  prefetch_pulse_a: assert property (
    host_ctl_wr && host_wdata[`HPC_BIT_PREFETCH] |=> prefetch_start)
    else $error("prefetch pulse missing");

  prefetch_once_a: assert property (
    !(host_ctl_wr && host_wdata[`HPC_BIT_PREFETCH]) |=> !prefetch_start)
    else $error("prefetch pulse without request");

  ready_polarity_a: assert property (
    port_ready |=> !ready_pin_n)
    else $error("ready pin polarity wrong");

  irq_set_wins_a: assert property (
    (host_ctl_wr && host_wdata[`HPC_BIT_TO_HOST_IRQ]) ||
    (cpu_ctl_wr && cpu_wdata[`HPC_BIT_TO_HOST_IRQ]) |=> to_host_irq)
    else $error("host interrupt bit not set");

  host_irq_a: assert property (
    cpu_ctl_wr && cpu_wdata[`HPC_BIT_TO_HOST_IRQ] |=> ##1 !host_irq_pin_n)
    else $error("host interrupt pin not asserted");

  cpu_irq_a: assert property (
    host_ctl_wr && host_wdata[`HPC_BIT_TO_CPU_IRQ] |=> ##1 cpu_irq)
    else $error("processor interrupt not raised");

  addr_ro_a: assert property (
    !host_addr_wr |=> $stable(host_write_address) && $stable(host_read_address))
    else $error("address register changed without host write");

  release_cov: cover property (port_hold_reset ##1 !port_hold_reset);
  split_cov:   cover property (host_addr_wr && split_addr_mode && addr_reg_select);
  irq_cov:     cover property (host_ctl_wr && host_wdata[`HPC_BIT_TO_CPU_IRQ]);
  gpio_cov:    cover property (!host_addr_pins_oe_n[0]);
  prefetch_cov: cover property (prefetch_start);
endmodule

// ### hpc_host_model.sv
// Behavioural model of the external host on the parallel host bus
`timescale 1ns/1ps

module hpc_host_model (
  input  wire logic        clk,
  input  wire logic        ready_pin_n,
  input  wire logic [31:0] host_rdata,
  output logic             host_rd,
  output logic             host_wr,
  output logic      [1:0]  access_select_pins,
  output logic      [31:0] host_wdata
);
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    access_select_pins = 2'b01;
    host_wdata = 32'h00000000;
  end

  // One host access, launched and ended on falling edges
  task automatic access(input logic wr, input logic [1:0] sel, input logic [31:0] wd,
                        output logic [31:0] rd, output bit to);
    int n;
    begin
      n = 0;
      to = 1'b0;
      rd = 32'h00000000;
      @(negedge clk);
      while (ready_pin_n !== 1'b0 && n < 64) begin
        n++;
        @(negedge clk);
      end
      if (n >= 64) begin
        to = 1'b1;
      end else begin
        // select and data held for the access
        access_select_pins = sel;
        host_wdata = wd;
        host_wr = wr;
        host_rd = !wr;
        @(negedge clk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        rd = host_rdata;
        host_wdata = ~wd;
        access_select_pins = ~sel;
      end
    end
  endtask
endmodule

// ### host_port_ctrl_regs_test.sv
// Self-checking testbench for the host port control block
`timescale 1ns/1ps

module host_port_ctrl_regs_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cpu_rd = 1'b0;
  logic        cpu_wr = 1'b0;
  logic [31:0] cpu_addr = 32'h00000000;
  logic [31:0] cpu_wdata = 32'h00000000;
  logic [31:0] cpu_rdata;
  logic        host_rd;
  logic        host_wr;
  logic [1:0]  access_select_pins;
  logic [31:0] host_wdata;
  logic [31:0] host_rdata;
  logic        port_ready = 1'b1;
  logic [1:0]  pin_function_enable = 2'b00;
  logic [15:0] ext_level = 16'h5A3C;
  logic [15:0] host_addr_pins_in;
  logic [15:0] pins_out;
  logic [15:0] pins_oe_n;
  logic        ready_pin_n;
  logic        host_irq_pin_n;
  logic        cpu_irq;
  logic        port_hold_reset;
  logic        prefetch_start;
  logic        split_addr_mode;
  logic        halfword_order;
  logic [31:0] host_write_address;
  logic [31:0] host_read_address;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_tests = 0;

  always #2.5 clk = ~clk;
  assign host_addr_pins_in = (~pins_oe_n & pins_out) | (pins_oe_n & ext_level);

  hpc_host_port_ctrl uut (
    .clk(clk), .rst_n(rst_n), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .host_rd(host_rd), .host_wr(host_wr),
    .access_select_pins(access_select_pins), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .port_ready(port_ready),
    .pin_function_enable(pin_function_enable), .host_addr_pins_in(host_addr_pins_in),
    .host_addr_pins_out(pins_out), .host_addr_pins_oe_n(pins_oe_n),
    .ready_pin_n(ready_pin_n), .host_irq_pin_n(host_irq_pin_n), .cpu_irq(cpu_irq),
    .port_hold_reset(port_hold_reset), .prefetch_start(prefetch_start),
    .split_addr_mode(split_addr_mode), .halfword_order(halfword_order),
    .host_write_address(host_write_address), .host_read_address(host_read_address)
  );

  hpc_host_model host (
    .clk(clk), .ready_pin_n(ready_pin_n), .host_rdata(host_rdata), .host_rd(host_rd),
    .host_wr(host_wr), .access_select_pins(access_select_pins), .host_wdata(host_wdata)
  );

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cpu_write(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask

  task automatic cpu_read(input logic [31:0] a, output logic [31:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic hacc(input logic wr, input logic [1:0] s, input logic [31:0] d,
                      output logic [31:0] r);
    bit to;
    host.access(wr, s, d, r, to);
    if (to) begin
      num_errors++;
      $display("MISMATCH t=%0t host access stalled", $time);
      tally_and_finish();
    end
  endtask

  task automatic hw(input logic [1:0] s, input logic [31:0] d);
    logic [31:0] r;
    hacc(1'b1, s, d, r);
  endtask

  task automatic reset_values();
    logic [31:0] addrs [6];
    logic [31:0] exps [6];
    addrs = '{32'h43000020, 32'h43000024, 32'h43000030, 32'h43000034,
              32'h43000038, 32'h43000040};
    exps = '{32'h00000000, 32'h00000000, 32'h00000080, 32'h00000000,
             32'h00000000, 32'h00000000};
    for (int i = 0; i < 6; i++) begin
      cpu_read(addrs[i], rd);
      chk(rd & ~32'h00000008, exps[i]);
    end
    hacc(1'b0, 2'b00, 32'h0, rd);
    chk(rd & 32'h00000480, 32'h00000000);
    hw(2'b00, 32'h00000004);
    cyc(3);
    chk(host_irq_pin_n, 1'b1);
    cpu_write(32'h43000030, 32'h00000000);
    chk(port_hold_reset, 1'b0);
  endtask

  task automatic control_bits();
    hw(2'b00, 32'h00000E11);
    chk(prefetch_start, 1'b1);
    cyc(1);
    chk(prefetch_start, 1'b0);
    hacc(1'b0, 2'b00, 32'h0, rd);
    chk(rd & 32'h00000FFF, 32'h00000B09);
    chk({split_addr_mode, halfword_order}, 2'b11);
    cpu_write(32'h43000030, 32'h00000000);
    cpu_read(32'h43000030, rd);
    chk(rd & 32'h00000FF7, 32'h00000B01);
  endtask

  task automatic address_regs();
    hw(2'b10, 32'h12345678);
    chk(host_read_address, 32'h12345678);
    chk(host_write_address, 32'h00000000);
    hw(2'b00, 32'h00000200);
    hw(2'b10, 32'h9ABCDEF0);
    chk(host_write_address, 32'h9ABCDEF0);
    cpu_write(32'h43000034, 32'hFFFFFFFF);
    cpu_write(32'h43000038, 32'hFFFFFFFF);
    cpu_read(32'h43000034, rd);
    chk(rd, 32'h9ABCDEF0);
    cpu_read(32'h43000038, rd);
    chk(rd, 32'h12345678);
    hacc(1'b0, 2'b10, 32'h0, rd);
    chk(rd, 32'h9ABCDEF0);
    hacc(1'b0, 2'b11, 32'h0, rd);
    chk(rd, 32'h00000000);
    hw(2'b00, 32'h00000000);
    hw(2'b10, 32'h0F0F0F0F);
    chk({host_write_address, host_read_address}, {2{32'h0F0F0F0F}});
  endtask

  task automatic interrupts_and_ready();
    port_ready = 1'b0;
    fork
      hw(2'b00, 32'h00000004);
      begin
        cyc(8);
        chk(host_irq_pin_n, 1'b1);
        chk(ready_pin_n, 1'b1);
        port_ready = 1'b1;
      end
    join
    cyc(3);
    chk({host_irq_pin_n, cpu_irq}, 2'b00);
    cpu_write(32'h43000030, 32'h00000002);
    cyc(3);
    chk({host_irq_pin_n, cpu_irq, ready_pin_n}, 3'b110);
    cpu_write(32'h43000030, 32'h00000000);
    cyc(3);
    chk(cpu_irq, 1'b0);
    hw(2'b00, 32'h00000002);
    cyc(3);
    chk(cpu_irq, 1'b1);
    cpu_write(32'h43000030, 32'h00000004);
    cyc(3);
    chk(host_irq_pin_n, 1'b0);
  endtask

  task automatic addr_gpio();
    cpu_write(32'h43000020, 32'h000000FF);
    pin_function_enable = 2'b11;
    cpu_write(32'h43000024, 32'h0000A5C3);
    cyc(2);
    chk({pins_out[7:0], pins_oe_n}, {8'hC3, 16'hFF00});
    cpu_read(32'h43000024, rd);
    chk(rd, 32'h00005AC3);
    cpu_read(32'h43000020, rd);
    chk(rd, 32'h000000FF);
    cpu_write(32'h43000020, 32'h0000FFFF);
    cyc(2);
    chk({pins_out, pins_oe_n}, {16'h00C3, 16'h0000});
    pin_function_enable = 2'b01;
    cyc(2);
    chk(pins_oe_n, 16'hFF00);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    reset_values();
    control_bits();
    address_regs();
    interrupts_and_ready();
    addr_gpio();
    tally_and_finish();
  end
endmodule
